// File: include/port_pin_config_consts.svh
// Summary of operation
// - An input-mode bit of one means digital input; zero means analog input.
// - After reset every input-mode bit reads one, so all pins are digital.
// - An analog pin has its pull-up, output driver and input receiver switched off.
// - Only the output-mode bit picks open-drain or push-pull, even for routed pins.
// - With the global pull-up disable at zero, open-drain pins get a weak pull-up.
// - The global pull-up disable has no effect on push-pull pins.
// - A pin driving a logic zero never has its weak pull-up on.
// - Routing becomes active only when software writes one to the enable bit.
// - While routing is off, pins act as plain inputs and selects are ignored.
// - While routing is off, every routable pin has its output driver disabled.
// - Routed functions land only on routable pins whose skip bit is zero.
// - Fixed functions observe pins whether used as plain pins or by routing.
// - Fixed functions see nothing on a pin in analog input mode.
// - Each selected function, in priority order, takes the lowest unassigned pin.
// - A pin with its skip bit set counts as already assigned.
// - An analog pin reads back zero; a digital pin reads the pad level.
`ifndef PORT_PIN_CONFIG_CONSTS_SVH
`define PORT_PIN_CONFIG_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_INPUT_MODE     6'h00
`define OFS_OUTPUT_MODE    6'h04
`define OFS_ROUTE_SKIP     6'h08
`define OFS_PERIPH_SEL_A   6'h0c
`define OFS_PERIPH_SEL_B   6'h10
`define OFS_ROUTE_CONTROL  6'h14
`define OFS_PIN_LATCH      6'h18
`define OFS_PIN_READBACK   6'h1c
`define OFS_ROUTE_ASSIGNED 6'h20

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define BIT_GLOBAL_PULLUP_DISABLE 0
`define BIT_ROUTE_MATRIX_ENABLE   0
`define RST_INPUT_MODE            32'hffffffff
`define RST_OUTPUT_MODE           32'h00000000
`define RST_ROUTE_SKIP            32'h00000000
`define RST_PERIPH_SEL            8'h00
`define RST_PIN_LATCH             32'hffffffff
`define RST_PAD_CTRL              4'h3

// ----------------------------------------------------------------------------
// Bus answers and fixed-function pin
// ----------------------------------------------------------------------------
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10
`define CONV_START_PIN 6

`endif

// File: include/port_pin_config_pkg.sv
package port_pin_config_pkg;

  // Per-pad controls towards the analog pad cell.
  typedef struct packed {
    logic out;
    logic oe;
    logic pullup_en;
    logic rx_en;
  } pad_ctrl_s;

endpackage

// File: src/route_assign.sv
`timescale 1ns/1ps
`default_nettype none
module route_assign
  import port_pin_config_pkg::*;
#(
  parameter int NUM_PINS  = 24,
  parameter int NUM_FUNCS = 8,
  parameter int PW        = $clog2(NUM_PINS),
  parameter int FW        = $clog2(NUM_FUNCS)
)
(
  input  wire logic [NUM_PINS-1:0]  skip,
  input  wire logic [NUM_FUNCS-1:0] func_en,
  output logic      [NUM_PINS-1:0]  owner_valid,
  output logic      [FW-1:0]        owner [NUM_PINS]
);

  function automatic logic [PW-1:0] lowest_set(input logic [NUM_PINS-1:0] v);
    logic [PW-1:0] idx;
    idx = '0;
    for (int i = NUM_PINS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = PW'(i);
      end
    end
    return idx;
  endfunction

  // Function 0 has highest priority; a skipped pin is simply never free.
  always_comb
  begin
    logic [NUM_PINS-1:0] free;
    logic [PW-1:0]       pick;
    free = ~skip;
    pick = '0;
    owner_valid = '0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      owner[p] = '0;
    end
    for (int f = 0; f < NUM_FUNCS; f++)
    begin
      if (func_en[f] && (|free))
      begin
        pick              = lowest_set(free);
        owner_valid[pick] = 1'b1;
        owner[pick]       = FW'(f);
        free[pick]        = 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: src/port_pin_config_crossbar_enable.sv
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_config_consts.svh"
module port_pin_config_crossbar_enable
  import port_pin_config_pkg::*;
#(
  parameter int NUM_PINS  = 24,
  parameter int NUM_FUNCS = 8,
  parameter int FW        = $clog2(NUM_FUNCS)
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [5:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [5:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [NUM_PINS-1:0]  pad_in,
  output pad_ctrl_s [NUM_PINS-1:0]  pad_ctrl,
  input  wire logic [NUM_FUNCS-1:0] func_out,
  input  wire logic [NUM_FUNCS-1:0] func_oe,
  output logic      [NUM_FUNCS-1:0] func_in,
  output logic      [NUM_PINS-1:0]  fixed_event_level,
  output logic                      conversion_start_input
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [NUM_PINS-1:0]  pin_input_mode_bits_ff;
  logic [NUM_PINS-1:0]  pin_output_mode_bits_ff;
  logic [NUM_PINS-1:0]  pin_route_skip_bits_ff;
  logic [7:0]           peripheral_select_a_ff;
  logic [7:0]           peripheral_select_b_ff;
  logic [7:0]           route_matrix_control_ff;
  logic [NUM_PINS-1:0]  pin_latch_ff;
  logic                 route_matrix_enable;
  logic                 global_pullup_disable;

  // Bus state.
  logic                 aw_held_ff;
  logic                 w_held_ff;
  logic [5:0]           awaddr_ff;
  logic [31:0]          wdata_ff;
  logic [3:0]           wstrb_ff;
  logic                 bvalid_ff;
  logic [1:0]           bresp_ff;
  logic                 rvalid_ff;
  logic [31:0]          rdata_ff;
  logic [1:0]           rresp_ff;
  logic                 wr_fire;

  // Pin side.
  logic [NUM_PINS-1:0]  pad_meta_ff;
  logic [NUM_PINS-1:0]  pad_sync_ff;
  pad_ctrl_s [NUM_PINS-1:0] pad_ctrl_ff;
  pad_ctrl_s [NUM_PINS-1:0] nxt_pad_ctrl;
  logic [NUM_PINS-1:0]  owner_valid;
  logic [FW-1:0]        owner [NUM_PINS];
  logic [NUM_FUNCS-1:0] func_in_ff;
  logic [NUM_FUNCS-1:0] nxt_func_in;
  logic [NUM_PINS-1:0]  event_level_ff;
  logic [NUM_PINS-1:0]  pin_readback;
  logic [NUM_PINS-1:0]  oe_vec;
  logic [NUM_PINS-1:0]  out_vec;
  logic [NUM_PINS-1:0]  pu_vec;
  logic [NUM_PINS-1:0]  rx_vec;

  assign route_matrix_enable   = route_matrix_control_ff[`BIT_ROUTE_MATRIX_ENABLE];
  assign global_pullup_disable = peripheral_select_b_ff[`BIT_GLOBAL_PULLUP_DISABLE];

  function automatic logic [NUM_PINS-1:0] merge_pins(input logic [NUM_PINS-1:0] old_val,
                                                     input logic [31:0]         new_val,
                                                     input logic [3:0]          strb);
    logic [31:0] mask;
    mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return NUM_PINS'((32'(old_val) & ~mask) | (new_val & mask));
  endfunction

  function automatic logic is_mapped(input logic [5:0] addr);
    return (addr[5:2] <= `OFS_ROUTE_ASSIGNED >> 2);
  endfunction

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 6'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= is_mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Register updates land at the edge that raises bvalid; pins follow one edge later.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_input_mode_bits_ff  <= NUM_PINS'(`RST_INPUT_MODE);
      pin_output_mode_bits_ff <= NUM_PINS'(`RST_OUTPUT_MODE);
      pin_route_skip_bits_ff  <= NUM_PINS'(`RST_ROUTE_SKIP);
      peripheral_select_a_ff  <= `RST_PERIPH_SEL;
      peripheral_select_b_ff  <= `RST_PERIPH_SEL;
      route_matrix_control_ff <= `RST_PERIPH_SEL;
      pin_latch_ff            <= NUM_PINS'(`RST_PIN_LATCH);
    end
    else if (wr_fire)
    begin
      unique case (awaddr_ff & 6'h3c)
        `OFS_INPUT_MODE:
          pin_input_mode_bits_ff <= merge_pins(pin_input_mode_bits_ff, wdata_ff, wstrb_ff);
        `OFS_OUTPUT_MODE:
          pin_output_mode_bits_ff <= merge_pins(pin_output_mode_bits_ff, wdata_ff, wstrb_ff);
        `OFS_ROUTE_SKIP:
          pin_route_skip_bits_ff <= merge_pins(pin_route_skip_bits_ff, wdata_ff, wstrb_ff);
        `OFS_PERIPH_SEL_A:
          peripheral_select_a_ff <= wstrb_ff[0] ? wdata_ff[7:0] : peripheral_select_a_ff;
        `OFS_PERIPH_SEL_B:
          peripheral_select_b_ff <= wstrb_ff[0] ? wdata_ff[7:0] : peripheral_select_b_ff;
        `OFS_ROUTE_CONTROL:
          route_matrix_control_ff <= wstrb_ff[0] ? wdata_ff[7:0] : route_matrix_control_ff;
        `OFS_PIN_LATCH: pin_latch_ff <= merge_pins(pin_latch_ff, wdata_ff, wstrb_ff);
        // Read-only and unmapped words ignore writes.
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_axi_araddr & 6'h3c)
        `OFS_INPUT_MODE:     rdata_ff <= 32'(pin_input_mode_bits_ff);
        `OFS_OUTPUT_MODE:    rdata_ff <= 32'(pin_output_mode_bits_ff);
        `OFS_ROUTE_SKIP:     rdata_ff <= 32'(pin_route_skip_bits_ff);
        `OFS_PERIPH_SEL_A:   rdata_ff <= 32'(peripheral_select_a_ff);
        `OFS_PERIPH_SEL_B:   rdata_ff <= 32'(peripheral_select_b_ff);
        `OFS_ROUTE_CONTROL:  rdata_ff <= 32'(route_matrix_control_ff);
        `OFS_PIN_LATCH:      rdata_ff <= 32'(pin_latch_ff);
        `OFS_PIN_READBACK:   rdata_ff <= 32'(pin_readback);
        `OFS_ROUTE_ASSIGNED: rdata_ff <= 32'(owner_valid & {NUM_PINS{route_matrix_enable}});
        default:             rdata_ff <= 32'h00000000;
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Pad input synchroniser and read-back
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_meta_ff <= '1;
      pad_sync_ff <= '1;
    end
    else
    begin
      pad_meta_ff <= pad_in;
      pad_sync_ff <= pad_meta_ff;
    end
  end

  // Analog pins have no receiver, so they read as zero.
  assign pin_readback = pad_sync_ff & pin_input_mode_bits_ff;

  // --------------------------------------------------------------------------
  // Priority assignment
  // --------------------------------------------------------------------------
  route_assign #(
    .NUM_PINS  (NUM_PINS),
    .NUM_FUNCS (NUM_FUNCS)
  ) u_route_assign (
    .skip        (pin_route_skip_bits_ff),
    .func_en     (peripheral_select_a_ff[NUM_FUNCS-1:0]),
    .owner_valid (owner_valid),
    .owner       (owner)
  );

  // --------------------------------------------------------------------------
  // Pad control
  // --------------------------------------------------------------------------
  // A peripheral that does not drive its function is seen as a released high.
  always_comb
  begin
    logic drive_val;
    logic active;
    drive_val    = 1'b1;
    active       = 1'b0;
    nxt_pad_ctrl = '0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      drive_val = (route_matrix_enable && owner_valid[p]) ?
                  (func_oe[owner[p]] ? func_out[owner[p]] : 1'b1) : pin_latch_ff[p];
      active = route_matrix_enable && pin_input_mode_bits_ff[p];
      if (pin_output_mode_bits_ff[p])
      begin
        nxt_pad_ctrl[p].oe  = active;
        nxt_pad_ctrl[p].out = drive_val;
      end
      else
      begin
        nxt_pad_ctrl[p].oe  = active && !drive_val;
        nxt_pad_ctrl[p].out = 1'b0;
      end
      nxt_pad_ctrl[p].pullup_en = pin_input_mode_bits_ff[p] && !pin_output_mode_bits_ff[p]
                                  && !global_pullup_disable
                                  && !(nxt_pad_ctrl[p].oe && !nxt_pad_ctrl[p].out);
      nxt_pad_ctrl[p].rx_en     = pin_input_mode_bits_ff[p];
    end
  end

  // Function inputs read the pad only through an assigned digital pin.
  always_comb
  begin
    nxt_func_in = '1;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      if (route_matrix_enable && owner_valid[p] && pin_input_mode_bits_ff[p])
      begin
        nxt_func_in[owner[p]] = pad_sync_ff[p];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_ctrl_ff    <= {NUM_PINS{`RST_PAD_CTRL}};
      func_in_ff     <= '1;
      event_level_ff <= '0;
    end
    else
    begin
      pad_ctrl_ff    <= nxt_pad_ctrl;
      func_in_ff     <= nxt_func_in;
      event_level_ff <= pad_sync_ff & pin_input_mode_bits_ff;
    end
  end

  assign pad_ctrl               = pad_ctrl_ff;
  assign func_in                = func_in_ff;
  assign fixed_event_level      = event_level_ff;
  assign conversion_start_input = event_level_ff[`CONV_START_PIN];

  for (genvar g = 0; g < NUM_PINS; g++)
  begin : g_vec
    assign oe_vec[g]  = pad_ctrl_ff[g].oe;
    assign out_vec[g] = pad_ctrl_ff[g].out;
    assign pu_vec[g]  = pad_ctrl_ff[g].pullup_en;
    assign rx_vec[g]  = pad_ctrl_ff[g].rx_en;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_RESET_DIGITAL: assert property (!$past(aresetn) |-> &pin_input_mode_bits_ff)
    else $error("input mode bits not all one after reset");
  AST_ANALOG_OFF: assert property (
      ((oe_vec | pu_vec | rx_vec) & ~$past(pin_input_mode_bits_ff)) == '0)
    else $error("analog pin has driver, pull-up or receiver on");
  AST_PULLUP_OD: assert property (
      !$past(global_pullup_disable) |->
      ((($past(pin_input_mode_bits_ff) & ~$past(pin_output_mode_bits_ff))
        & ~(oe_vec & ~out_vec)) & ~pu_vec) == '0)
    else $error("open-drain pin lacks weak pull-up");
  AST_PUSHPULL_NO_PU: assert property ((pu_vec & $past(pin_output_mode_bits_ff)) == '0)
    else $error("push-pull pin has weak pull-up");
  AST_LOW_NO_PU: assert property ((pu_vec & oe_vec & ~out_vec) == '0)
    else $error("pull-up on while driving zero");
  AST_ENABLE_BY_WRITE: assert property ($rose(route_matrix_enable) |-> $past(wr_fire))
    else $error("routing enabled without a register write");
  AST_DISABLED_INPUTS: assert property (!$past(route_matrix_enable) |-> func_in_ff == '1)
    else $error("function input routed while routing is off");
  AST_DISABLED_NO_OE: assert property (!route_matrix_enable |=> oe_vec == '0)
    else $error("output driver on while routing is off");
  AST_SKIP_RESPECTED: assert property ((owner_valid & pin_route_skip_bits_ff) == '0)
    else $error("function assigned to skipped pin");
  AST_FIXED_ANALOG: assert property (
      !$past(pin_input_mode_bits_ff[`CONV_START_PIN]) |-> !conversion_start_input)
    else $error("fixed function sees analog pin");
  AST_READBACK_ZERO: assert property ((pin_readback & ~pin_input_mode_bits_ff) == '0)
    else $error("analog pin reads non-zero");
  AST_TIMING: assert property (rx_vec == $past(pin_input_mode_bits_ff))
    else $error("receiver enable not one cycle behind input mode");

endmodule
`default_nettype wire

// File: test/pad_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module pad_board_model
  import port_pin_config_pkg::*;
#(
  parameter int NUM_PINS = 24
)
(
  input  wire logic                     clk,
  input  wire pad_ctrl_s [NUM_PINS-1:0] pad_ctrl,
  input  wire logic [NUM_PINS-1:0]      ext_en,
  input  wire logic [NUM_PINS-1:0]      ext_val,
  output logic      [NUM_PINS-1:0]      pad
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // A pad nobody drives or pulls toggles every cycle, so a floating
  // pin can never pass for a steady level by accident.
  logic flip_ff = 1'h0;

  always @(posedge clk)
  begin
    flip_ff <= !flip_ff;
  end

  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (pad_ctrl[i].oe)
        pad[i] = pad_ctrl[i].out;
      else if (ext_en[i])
        pad[i] = ext_val[i];
      else
        pad[i] = pad_ctrl[i].pullup_en | flip_ff;
    end
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_config_consts.svh"
module tb_top
  import port_pin_config_pkg::*;
  ;
  logic             aclk          = 1'h0;
  logic             aresetn       = 1'h0;
  logic [5:0]       s_axi_awaddr  = 6'h00;
  logic             s_axi_awvalid = 1'h0;
  logic             s_axi_awready;
  logic [31:0]      s_axi_wdata   = 32'h0;
  logic [3:0]       s_axi_wstrb   = 4'hf;
  logic             s_axi_wvalid  = 1'h0;
  logic             s_axi_wready;
  logic [1:0]       s_axi_bresp;
  logic             s_axi_bvalid;
  logic             s_axi_bready  = 1'h0;
  logic [5:0]       s_axi_araddr  = 6'h00;
  logic             s_axi_arvalid = 1'h0;
  logic             s_axi_arready;
  logic [31:0]      s_axi_rdata;
  logic [1:0]       s_axi_rresp;
  logic             s_axi_rvalid;
  logic             s_axi_rready  = 1'h0;
  logic [23:0]      pad_in;
  pad_ctrl_s [23:0] pad_ctrl;
  logic [7:0]       func_out      = 8'h00;
  logic [7:0]       func_oe       = 8'h00;
  logic [7:0]       func_in;
  logic [23:0]      fixed_event_level;
  logic             conversion_start_input;
  logic [23:0]      ext_en        = 24'h0;
  logic [23:0]      ext_val       = 24'h0;
  int               num_errors    = 0;
  int               n_tests       = 0;

  always #50 aclk = !aclk;

  port_pin_config_crossbar_enable #(.NUM_PINS(24), .NUM_FUNCS(8)) i_port_pin_config_crossbar_enable (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_ctrl, .func_out,
    .func_oe, .func_in, .fixed_event_level, .conversion_start_input);

  pad_board_model #(.NUM_PINS(24)) i_pad_board_model (
    .clk(aclk), .pad_ctrl, .ext_en, .ext_val, .pad(pad_in));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  // Drives land 1 ns after the edge and handshakes are judged at the
  // falling edge, so no sample races the edge that updates the design.
  task automatic tick();
    @(posedge aclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ha;
    logic hw;
    logic hb;
    n = 0;
    hb = 1'h0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!hb)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      if (hb)
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      tick();
      if (ha)
        s_axi_awvalid <= 1'h0;
      if (hw)
        s_axi_wvalid <= 1'h0;
      n++;
      if (n == 40)
      begin
        num_errors++;
        print_verdict();
      end
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ha;
    logic hr;
    n = 0;
    hr = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!hr)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      if (hr)
      begin
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
      tick();
      if (ha)
        s_axi_arvalid <= 1'h0;
      n++;
      if (n == 40)
      begin
        num_errors++;
        print_verdict();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) tick();
    aresetn <= 1'h1;
    tick();
    rd(`OFS_INPUT_MODE, 32'h00ffffff, `RESP_OKAY);
    rd(`OFS_ROUTE_ASSIGNED, 32'h0, `RESP_OKAY);
    for (int i = 0; i < 24; i++)
      chk({29'h0, pad_ctrl[i][2:0]}, 32'h3);
    chk({8'h0, fixed_event_level}, 32'h00ffffff);
    $display("test reset done");
    wr(`OFS_PIN_LATCH, 32'h00fffffe, `RESP_OKAY);
    chk({31'h0, pad_ctrl[0].oe}, 32'h0);
    wr(`OFS_ROUTE_CONTROL, 32'h1, `RESP_OKAY);
    chk({28'h0, pad_ctrl[0]}, 32'h5);
    chk({28'h0, pad_ctrl[1]}, 32'h3);
    repeat (2) tick();
    rd(`OFS_PIN_READBACK, 32'h00fffffe, `RESP_OKAY);
    $display("test drive done");
    wr(`OFS_OUTPUT_MODE, 32'h2, `RESP_OKAY);
    chk({28'h0, pad_ctrl[1]}, 32'hd);
    wr(`OFS_PERIPH_SEL_B, 32'h1, `RESP_OKAY);
    chk({28'h0, pad_ctrl[2]}, 32'h1);
    chk({28'h0, pad_ctrl[1]}, 32'hd);
    wr(`OFS_PERIPH_SEL_B, 32'h0, `RESP_OKAY);
    $display("test pullup done");
    ext_en <= 24'h000014;
    ext_val <= 24'h000004;
    wr(`OFS_INPUT_MODE, 32'h00fffffb, `RESP_OKAY);
    chk({29'h0, pad_ctrl[2][2:0]}, 32'h0);
    wr(`OFS_ROUTE_SKIP, 32'h4, `RESP_OKAY);
    rd(`OFS_PIN_READBACK, 32'h00ffffea, `RESP_OKAY);
    chk({8'h0, fixed_event_level}, 32'h00ffffea);
    $display("test analog done");
    func_oe <= 8'h01;
    wr(`OFS_ROUTE_SKIP, 32'h7, `RESP_OKAY);
    wr(`OFS_PERIPH_SEL_A, 32'h3, `RESP_OKAY);
    rd(`OFS_ROUTE_ASSIGNED, 32'h18, `RESP_OKAY);
    chk({28'h0, pad_ctrl[3]}, 32'h5);
    repeat (3) tick();
    chk({24'h0, func_in}, 32'hfc);
    wr(`OFS_PERIPH_SEL_A, 32'h2, `RESP_OKAY);
    rd(`OFS_ROUTE_ASSIGNED, 32'h08, `RESP_OKAY);
    wr(`OFS_ROUTE_CONTROL, 32'h0, `RESP_OKAY);
    rd(`OFS_ROUTE_ASSIGNED, 32'h0, `RESP_OKAY);
    chk({31'h0, pad_ctrl[0].oe}, 32'h0);
    repeat (3) tick();
    chk({24'h0, func_in}, 32'hff);
    $display("test routing done");
    ext_en <= 24'h000054;
    repeat (4) tick();
    chk({31'h0, conversion_start_input}, 32'h0);
    chk({31'h0, fixed_event_level[2]}, 32'h0);
    $display("test fixed done");
    rd(6'h24, 32'h0, `RESP_SLVERR);
    wr(6'h24, 32'h0, `RESP_SLVERR);
    wr(`OFS_PIN_READBACK, 32'h0, `RESP_OKAY);
    rd(`OFS_ROUTE_SKIP, 32'h7, `RESP_OKAY);
    $display("test bus done");
    print_verdict();
  end
endmodule
`default_nettype wire
